// [rtl/svb_receiver.sv]
// Serial voltage-code bus receiver with APB register access.
// Assumes the bus master drives the serial clock; the link logic oversamples
// both serial lines on i_link_clk, which must run well above the bus rate.
//
// How it works
// - Receive only: data line driven low solely for acknowledges, never read data.
// - Bus is idle whenever clock and data lines both stay high.
// - START: data falls while clock high, from idle or mid-command; receiver detects it.
// - STOP: data rises while clock high; receiver detects it.
// - Works at 3.4MHz and at 100kHz, 400kHz and 1.7MHz bus clocks.
// - Address prefix 110, fourth bit ignored; acknowledge only when not programming.
// - Address bits 3:1 pick second core (except in combined mode), first core, bridge rails.
// - Hold data line low over the acknowledge clock high period.
// - Data bit 7 is active-low power-save flag; bits 6:0 the code.
`timescale 1ns/1ps
`include "svb_defs.svh"

module svb_receiver
  import svb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_vid_bus_clock,
  input wire logic i_vid_bus_data,
  output logic o_vid_bus_data,
  output logic o_vid_bus_data_oe,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [6:0] o_first_core_code,
  output logic [6:0] o_second_core_code,
  output logic [6:0] o_bridge_rail_code,
  output logic o_power_save_indicator_n
);

  // Reset release, one copy per domain
  logic rst_m1_q, rst_m_n;
  logic rst_l1_q, rst_l_n;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_m1_q <= 1'b0;
      rst_m_n <= 1'b0;
    end else begin
      rst_m1_q <= 1'b1;
      rst_m_n <= rst_m1_q;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_l1_q <= 1'b0;
      rst_l_n <= 1'b0;
    end else begin
      rst_l1_q <= 1'b1;
      rst_l_n <= rst_l1_q;
    end
  end

  // Link domain: line synchronisers
  logic scl1_q, scl2_q, scl3_q;
  logic sda1_q, sda2_q, sda3_q;
  logic prog1_q, prog2_q;
  logic ctrl_prog_q;

  always_ff @(posedge i_link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      scl1_q <= 1'b1;
      scl2_q <= 1'b1;
      scl3_q <= 1'b1;
      sda1_q <= 1'b1;
      sda2_q <= 1'b1;
      sda3_q <= 1'b1;
      prog1_q <= 1'b0;
      prog2_q <= 1'b0;
    end else begin
      scl1_q <= i_vid_bus_clock;
      scl2_q <= scl1_q;
      scl3_q <= scl2_q;
      sda1_q <= i_vid_bus_data;
      sda2_q <= sda1_q;
      sda3_q <= sda2_q;
      prog1_q <= ctrl_prog_q;
      prog2_q <= prog1_q;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall, idle_now;
  // Repeated START is accepted so a fresh command can replace a stale one
  assign start_det = scl2_q && scl3_q && sda3_q && !sda2_q;
  assign stop_det = scl2_q && scl3_q && !sda3_q && sda2_q;
  assign scl_rise = scl2_q && !scl3_q;
  assign scl_fall = !scl2_q && scl3_q;
  assign idle_now = scl2_q && sda2_q;

  // Link domain: receive state machine
  svb_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [2:0] sel_q;
  logic [10:0] hold_q;
  logic xfer_tgl_q;
  logic ack_q;
  logic idle_q;
  logic addr_ok;

  assign addr_ok = (shift_q[`SVB_ADDR_PFX_MSB:`SVB_ADDR_PFX_LSB] == `SVB_ADDR_PREFIX)
                   && !prog2_q;

  always_ff @(posedge i_link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      idle_q <= 1'b1;
    end else begin
      idle_q <= idle_now;
    end
  end

  always_ff @(posedge i_link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      state_q <= SVB_IDLE;
      cnt_q <= `SVB_CNT_ZERO;
      shift_q <= 8'h00;
      sel_q <= 3'h0;
      ack_q <= 1'b0;
    end else if (start_det) begin
      state_q <= SVB_ADDR;
      cnt_q <= `SVB_CNT_ZERO;
      ack_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= SVB_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (state_q)
        SVB_ADDR, SVB_DATA: begin
          if (scl_rise && cnt_q != `SVB_BITS_PER_BYTE) begin
            shift_q <= {shift_q[6:0], sda2_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `SVB_BITS_PER_BYTE) begin
            cnt_q <= `SVB_CNT_ZERO;
            if (state_q == SVB_DATA) begin
              ack_q <= 1'b1;
              state_q <= SVB_DACK;
            end else if (addr_ok) begin
              sel_q <= shift_q[`SVB_SEL_LSB+2:`SVB_SEL_LSB];
              ack_q <= 1'b1;
              state_q <= SVB_AACK;
            end else begin
              state_q <= SVB_SKIP;
            end
          end
        end
        SVB_AACK: begin
          if (scl_fall) begin
            ack_q <= 1'b0;
            state_q <= SVB_DATA;
          end
        end
        SVB_DACK: begin
          if (scl_fall) begin
            ack_q <= 1'b0;
            state_q <= SVB_SKIP;
          end
        end
        SVB_IDLE, SVB_SKIP: begin
          ack_q <= 1'b0;
        end
        default: begin
          state_q <= SVB_IDLE;
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // Commit only once the data acknowledge has ended cleanly
  always_ff @(posedge i_link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      hold_q <= 11'h000;
      xfer_tgl_q <= 1'b0;
    end else if (state_q == SVB_DACK && scl_fall && !start_det && !stop_det) begin
      hold_q <= {sel_q, shift_q};
      xfer_tgl_q <= ~xfer_tgl_q;
    end
  end

  // Only ever pulls low; no read path exists
  always_ff @(posedge i_link_clk or negedge rst_l_n) begin
    if (!rst_l_n) begin
      o_vid_bus_data <= 1'b0;
    end else begin
      o_vid_bus_data <= 1'b0;
    end
  end
  // Straight from the acknowledge flop, so the pull-down beats the fast clock rise
  assign o_vid_bus_data_oe = ack_q;

  // Main domain: crossings from the link
  logic tgl1_q, tgl2_q, tgl3_q;
  logic idl1_q, idl2_q;
  logic load;

  always_ff @(posedge i_mclk or negedge rst_m_n) begin
    if (!rst_m_n) begin
      tgl1_q <= 1'b0;
      tgl2_q <= 1'b0;
      tgl3_q <= 1'b0;
      idl1_q <= 1'b1;
      idl2_q <= 1'b1;
    end else begin
      tgl1_q <= xfer_tgl_q;
      tgl2_q <= tgl1_q;
      tgl3_q <= tgl2_q;
      idl1_q <= idle_q;
      idl2_q <= idl1_q;
    end
  end

  // Hold word changes with each toggle and stays stable for many link cycles after it
  assign load = tgl2_q ^ tgl3_q;

  // Decoded outputs
  logic ctrl_comb_q;
  logic [7:0] cmd_cnt_q;

  always_ff @(posedge i_mclk or negedge rst_m_n) begin
    if (!rst_m_n) begin
      o_first_core_code <= `SVB_CODE_RESET;
      o_second_core_code <= `SVB_CODE_RESET;
      o_bridge_rail_code <= `SVB_CODE_RESET;
      o_power_save_indicator_n <= `SVB_PSI_RESET;
      cmd_cnt_q <= 8'h00;
    end else if (load) begin
      cmd_cnt_q <= cmd_cnt_q + 8'h01;
      o_power_save_indicator_n <= hold_q[`SVB_PSI_BIT];
      if (hold_q[`SVB_HOLD_SEL_LSB+`SVB_SEL_SECOND] && !ctrl_comb_q) begin
        o_second_core_code <= hold_q[`SVB_CODE_MSB:0];
      end
      if (hold_q[`SVB_HOLD_SEL_LSB+`SVB_SEL_FIRST]) begin
        o_first_core_code <= hold_q[`SVB_CODE_MSB:0];
      end
      if (hold_q[`SVB_HOLD_SEL_LSB+`SVB_SEL_BRIDGE]) begin
        o_bridge_rail_code <= hold_q[`SVB_CODE_MSB:0];
      end
    end
  end

  // APB slave, one wait state
  logic acc;
  logic mapped;
  logic [31:0] rd_d;

  assign acc = i_psel && i_penable;

  always_comb begin
    mapped = 1'b1;
    rd_d = 32'h0000_0000;
    case (i_paddr)
      `SVB_CTRL_OFS: begin
        rd_d[`SVB_CTRL_PROG_BIT] = ctrl_prog_q;
        rd_d[`SVB_CTRL_COMB_BIT] = ctrl_comb_q;
      end
      `SVB_FIRST_OFS: rd_d[`SVB_CODE_MSB:0] = o_first_core_code;
      `SVB_SECOND_OFS: rd_d[`SVB_CODE_MSB:0] = o_second_core_code;
      `SVB_BRIDGE_OFS: rd_d[`SVB_CODE_MSB:0] = o_bridge_rail_code;
      `SVB_STATUS_OFS: begin
        rd_d[`SVB_STAT_IDLE_BIT] = idl2_q;
        rd_d[`SVB_STAT_PSI_BIT] = o_power_save_indicator_n;
        rd_d[`SVB_STAT_CNT_MSB:`SVB_STAT_CNT_LSB] = cmd_cnt_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_m_n) begin
    if (!rst_m_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (acc && !o_pready) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_d;
      o_pslverr <= !mapped;
    end else begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_m_n) begin
    if (!rst_m_n) begin
      ctrl_prog_q <= 1'(`SVB_CTRL_RESET >> `SVB_CTRL_PROG_BIT);
      ctrl_comb_q <= 1'(`SVB_CTRL_RESET >> `SVB_CTRL_COMB_BIT);
    end else if (acc && o_pready && i_pwrite && i_paddr == `SVB_CTRL_OFS) begin
      ctrl_prog_q <= i_pwdata[`SVB_CTRL_PROG_BIT];
      ctrl_comb_q <= i_pwdata[`SVB_CTRL_COMB_BIT];
    end
  end

  // Checks, link domain
  a_read_never_driven: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    o_vid_bus_data_oe |-> !o_vid_bus_data && (state_q == SVB_AACK || state_q == SVB_DACK))
    else $error("data line driven outside acknowledge");

  a_idle_seen: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    (scl2_q && sda2_q) |=> idle_q)
    else $error("idle bus not flagged");

  a_start_to_addr: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    start_det |=> state_q == SVB_ADDR && cnt_q == `SVB_CNT_ZERO && !ack_q)
    else $error("start not taken");

  a_stop_to_idle: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    stop_det |=> state_q == SVB_IDLE ##1 !o_vid_bus_data_oe)
    else $error("stop not taken");

  a_wrong_addr_nack: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    (state_q == SVB_ADDR && scl_fall && cnt_q == `SVB_BITS_PER_BYTE && !addr_ok
     && !start_det && !stop_det) |=> state_q == SVB_SKIP && !ack_q)
    else $error("foreign address acknowledged");

  a_ack_over_high: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    (state_q == SVB_AACK && $past(state_q) == SVB_AACK && scl_rise && !start_det && !stop_det)
    |=> o_vid_bus_data_oe)
    else $error("acknowledge not held over clock high");

  a_commit_after_ack: assert property (@(posedge i_link_clk) disable iff (!rst_l_n)
    (xfer_tgl_q != $past(xfer_tgl_q)) |-> $past(state_q) == SVB_DACK && state_q == SVB_SKIP)
    else $error("command committed without data acknowledge");

  c_start_seen: cover property (@(posedge i_link_clk) disable iff (!rst_l_n) start_det);
  c_addr_nack: cover property (@(posedge i_link_clk) disable iff (!rst_l_n)
    state_q == SVB_ADDR ##1 state_q == SVB_SKIP);
  c_full_command: cover property (@(posedge i_link_clk) disable iff (!rst_l_n)
    state_q == SVB_DACK ##1 state_q == SVB_SKIP);

  // Checks, main domain
  a_psi_and_code: assert property (@(posedge i_mclk) disable iff (!rst_m_n)
    (load && hold_q[`SVB_HOLD_SEL_LSB+`SVB_SEL_FIRST])
    |=> o_first_core_code == $past(hold_q[`SVB_CODE_MSB:0])
    && o_power_save_indicator_n == $past(hold_q[`SVB_PSI_BIT]))
    else $error("data byte decoded wrongly");

  a_combined_skip: assert property (@(posedge i_mclk) disable iff (!rst_m_n)
    (load && ctrl_comb_q) |=> $stable(o_second_core_code))
    else $error("second core written in combined mode");

  a_apb_one_wait: assert property (@(posedge i_mclk) disable iff (!rst_m_n)
    (acc && !o_pready) |=> o_pready ##1 !o_pready)
    else $error("apb answer timing wrong");

  c_rail_loaded: cover property (@(posedge i_mclk) disable iff (!rst_m_n) load);

endmodule : svb_receiver

// [rtl/svb_defs.svh]
// Constants for the serial voltage-code bus receiver.
// Assumes a 32-bit APB register bus and an active-low reset.
`ifndef SVB_DEFS_SVH
`define SVB_DEFS_SVH

// Register byte offsets
`define SVB_CTRL_OFS 8'h00
`define SVB_FIRST_OFS 8'h04
`define SVB_SECOND_OFS 8'h08
`define SVB_BRIDGE_OFS 8'h0c
`define SVB_STATUS_OFS 8'h10

// Control fields
`define SVB_CTRL_PROG_BIT 0
`define SVB_CTRL_COMB_BIT 1
`define SVB_CTRL_RESET 2'h0

// Status fields
`define SVB_STAT_IDLE_BIT 0
`define SVB_STAT_PSI_BIT 1
`define SVB_STAT_CNT_LSB 8
`define SVB_STAT_CNT_MSB 15

// Address byte: fixed prefix in bits 7:5, rail selects in bits 3:1
`define SVB_ADDR_PFX_MSB 7
`define SVB_ADDR_PFX_LSB 5
`define SVB_ADDR_PREFIX 3'h6
`define SVB_SEL_SECOND 2
`define SVB_SEL_FIRST 1
`define SVB_SEL_BRIDGE 0
`define SVB_SEL_LSB 1
`define SVB_HOLD_SEL_LSB 8

// Data byte: power-save indicator and voltage code
`define SVB_PSI_BIT 7
`define SVB_CODE_MSB 6
`define SVB_CODE_RESET 7'h00
`define SVB_PSI_RESET 1'h1

// Bit counter
`define SVB_BITS_PER_BYTE 4'h8
`define SVB_CNT_ZERO 4'h0

`endif

// [rtl/svb_pkg.sv]
// Types shared by the serial voltage-code bus receiver.
// Assumes the constants of svb_defs.svh are included where needed.
package svb_pkg;

  // Receiver states, one-hot
  typedef enum logic [5:0] {
    SVB_IDLE = 6'h01,
    SVB_ADDR = 6'h02,
    SVB_AACK = 6'h04,
    SVB_DATA = 6'h08,
    SVB_DACK = 6'h10,
    SVB_SKIP = 6'h20
  } svb_state_t;

endpackage : svb_pkg

// [tb/svb_master_model.sv]
// Behavioural bus master for the serial voltage-code bus.
// Assumes the receiver only pulls data low; the released data wire reads the pull-up level.
`timescale 1ns/1ps

module svb_master_model (
  input wire logic i_oe,
  output logic o_scl,
  output wire logic o_sda
);
  logic drv_q;
  assign o_sda = i_oe ? 1'b0 : drv_q;
  initial begin
    o_scl = 1'b1;
    drv_q = 1'b1;
  end
  task automatic put_bits(input logic [7:0] b, input int n, input int hp);
    for (int i = 7; i > 7 - n; i--) begin
      #(hp / 2) drv_q = b[i]; // Data moves only while the clock is low
      #(hp / 2) o_scl = 1'b1;
      #hp o_scl = 1'b0;
    end
  endtask : put_bits
  task automatic get_ack(input int hp, output logic ack);
    #(hp / 2) drv_q = 1'b1;
    #(hp / 2) o_scl = 1'b1;
    #(hp - 2) ack = ~o_sda;
    #2 o_scl = 1'b0;
  endtask : get_ack
  task automatic start_cond(input int hp);
    #(hp / 2) drv_q = 1'b1;
    #(hp / 2) o_scl = 1'b1;
    #(hp / 2) drv_q = 1'b0;
    #(hp / 2) o_scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond(input int hp);
    #(hp / 2) drv_q = 1'b0;
    #(hp / 2) o_scl = 1'b1;
    #(hp / 2) drv_q = 1'b1;
    #(hp * 4); // Idle gap, both lines high before any new start
  endtask : stop_cond
  // Mode 0 full, 1 stop after address, 2 stop mid data, 3 restart mid data
  task automatic cmd(input logic [7:0] a, input logic [7:0] d, input int hp, input int mode,
                     output logic aa, output logic da);
    da = 1'b0;
    start_cond(hp);
    if (mode == 3) begin
      put_bits(a, 8, hp);
      get_ack(hp, aa);
      put_bits(~d, 4, hp);
      start_cond(hp);
    end
    put_bits(a, 8, hp);
    get_ack(hp, aa);
    if (mode == 2) begin
      put_bits(d, 4, hp);
    end else if (mode != 1) begin
      put_bits(d, 8, hp);
      get_ack(hp, da);
    end
    stop_cond(hp);
  endtask : cmd
endmodule : svb_master_model

// [tb/svb_receiver_tb_top.sv]
// Self-checking bench for the serial voltage-code bus receiver.
// Assumes APB on i_mclk and a free-running 48 ns oversampling clock.
`timescale 1ns/1ps
`include "svb_defs.svh"

module svb_receiver_tb_top;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl, sda, oe, sdo, psi_n;
  logic [6:0] code1, code2, codeb;
  logic [6:0] e1 = 7'h00;
  logic [6:0] e2 = 7'h00;
  logic [6:0] eb = 7'h00;
  logic ep = 1'b1;
  logic [7:0] ncmd = 8'h00;
  logic prog = 1'b0;
  logic comb = 1'b0;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int num_checks = 0;
  int hp_tab[4] = '{5000, 1250, 294, 147};
  logic [7:0] d_tab[4] = '{8'h81, 8'h2a, 8'hff, 8'h55};

  always #50 mclk = ~mclk;
  always #24 link_clk = ~link_clk;

  svb_receiver i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_link_clk(link_clk),
    .i_vid_bus_clock(scl), .i_vid_bus_data(sda), .o_vid_bus_data(sdo),
    .o_vid_bus_data_oe(oe), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_first_core_code(code1), .o_second_core_code(code2),
    .o_bridge_rail_code(codeb), .o_power_save_indicator_n(psi_n));
  svb_master_model i_master (.i_oe(oe), .o_scl(scl), .o_sda(sda));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t apb answer timed out", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [7:0] a, input logic [7:0] d, input int hp, input int mode);
    logic aa, da, ok, done;
    ok = (a[7:5] === 3'b110) && !prog;
    done = ok && (mode == 0 || mode == 3);
    i_master.cmd(a, d, hp, mode, aa, da);
    chk(32'(aa), 32'(ok), "address ack");
    chk(32'(da), 32'(done), "data ack");
    if (done) begin
      if (a[3] && !comb) e2 = d[6:0];
      if (a[2]) e1 = d[6:0];
      if (a[1]) eb = d[6:0];
      ep = d[7];
      ncmd++;
    end
    repeat (10) @(posedge mclk);
    chk(32'(code1), 32'(e1), "first code");
    chk(32'(code2), 32'(e2), "second code");
    chk(32'(codeb), 32'(eb), "bridge code");
    chk(32'(psi_n), 32'(ep), "power save flag");
  endtask : run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  always @(posedge link_clk) begin
    if (oe === 1'b1 && sdo !== 1'b0) begin
      err_total++;
      $display("[FAIL] %0t data driven high", $time);
    end
  end

  initial begin
    #3000000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(32'(oe), 32'h0, "ack idle");
    chk(32'(psi_n), 32'h1, "reset flag");
    apb(1'b0, `SVB_CTRL_OFS, 32'h0);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(er), 32'h1, "unmapped error");
    apb(1'b0, `SVB_STATUS_OFS, 32'h0);
    chk(32'(rd[`SVB_STAT_IDLE_BIT]), 32'h1, "bus idle");
    $display("test reset done");
    for (int i = 0; i < 4; i++) run(8'hce, d_tab[i], hp_tab[i], 0);
    $display("test rates done");
    run(8'hd8, 8'h13, 294, 0);
    run(8'hc5, 8'h64, 294, 0);
    run(8'hc2, 8'h0f, 294, 0);
    apb(1'b1, `SVB_FIRST_OFS, 32'h7f);
    apb(1'b0, `SVB_FIRST_OFS, 32'h0);
    chk(rd, 32'(e1), "first code read");
    apb(1'b0, `SVB_SECOND_OFS, 32'h0);
    chk(rd, 32'(e2), "second code read");
    apb(1'b0, `SVB_BRIDGE_OFS, 32'h0);
    chk(rd, 32'(eb), "bridge code read");
    $display("test rail select done");
    run(8'he6, 8'h11, 294, 0);
    run(8'h4e, 8'h11, 294, 0);
    apb(1'b1, `SVB_CTRL_OFS, 32'h1);
    prog = 1'b1;
    run(8'hce, 8'h22, 294, 0);
    apb(1'b1, `SVB_CTRL_OFS, 32'h2);
    prog = 1'b0;
    comb = 1'b1;
    apb(1'b0, `SVB_CTRL_OFS, 32'h0);
    chk(rd, 32'h2, "control readback");
    run(8'hca, 8'h7e, 294, 0);
    apb(1'b1, `SVB_CTRL_OFS, 32'h0);
    comb = 1'b0;
    $display("test refusals done");
    run(8'hce, 8'h33, 294, 1);
    run(8'hce, 8'h44, 294, 2);
    run(8'hce, 8'h05, 294, 3);
    repeat (20) @(posedge mclk);
    apb(1'b0, `SVB_STATUS_OFS, 32'h0);
    chk(32'(rd[`SVB_STAT_IDLE_BIT]), 32'h1, "bus idle after");
    chk(32'(rd[`SVB_STAT_PSI_BIT]), 32'(ep), "status flag");
    chk(32'(rd[`SVB_STAT_CNT_MSB:`SVB_STAT_CNT_LSB]), 32'(ncmd), "command count");
    $display("test aborts done");
    complete_run();
  end
endmodule : svb_receiver_tb_top
